// *** cbsr_bus_cond.sv ***
`timescale 1ns/1ps
module cbsr_bus_cond (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  // line levels
  input  wire logic i_scl,
  input  wire logic i_sda,
  // events
  output logic      o_scl_rise,
  output logic      o_scl_fall,
  output logic      o_start,
  output logic      o_stop
);
  logic scl_q;
  logic sda_q;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  // sda moving while scl high marks a bus condition
  assign o_scl_rise = !scl_q && i_scl;
  assign o_scl_fall = scl_q && !i_scl;
  assign o_start    = scl_q && i_scl && sda_q && !i_sda;
  assign o_stop     = scl_q && i_scl && !sda_q && i_sda;
endmodule : cbsr_bus_cond

// *** cbsr_chk.sv ***
`timescale 1ns/1ps
module cbsr_chk #(
  parameter int QTR = 4
) (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  // bus lines
  input  wire logic h_scl_oe_n,
  input  wire logic h_sda_oe_n,
  input  wire logic t_sda_oe_n,
  input  wire logic scl,
  input  wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [7:0] run_q;
  logic [7:0] bit_q;
  logic       cond;
  // start or stop: sda moves while scl stays high
  assign cond = scl && scl_q && (sda != sda_q);
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // saturates so a long idle never wraps to a short level
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst)
      run_q <= 8'h00;
    else
      run_q <= (scl != scl_q) ? 8'h00 : run_q + {7'h00, ~&run_q};
  end
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst)
      bit_q <= 8'h00;
    else if (cond)
      bit_q <= 8'h00;
    else if (scl && !scl_q)
      bit_q <= bit_q + 8'h01;
  end
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  chk_reset_lines_free: assert property (disable iff (1'b0) !i_nrst |-> h_scl_oe_n && h_sda_oe_n && t_sda_oe_n)
    else $error("line driven in reset");
  chk_scl_low_time: assert property ((scl && !scl_q) |-> run_q >= QTR - 1)
    else $error("scl low too short");
  chk_scl_high_time: assert property ((!scl && scl_q) |-> run_q >= QTR - 1)
    else $error("scl high too short");
  chk_tgt_moves_low: assert property ($changed(t_sda_oe_n) |-> !scl && !$past(scl))
    else $error("target moved sda with scl high");
  chk_tgt_bit_held: assert property ($fell(t_sda_oe_n) |-> (!t_sda_oe_n) [*8])
    else $error("target bit not held");
  chk_one_driver: assert property ((scl && scl_q) |-> h_sda_oe_n || t_sda_oe_n)
    else $error("both ends drive sda");
  chk_byte_frame: assert property (cond |-> (bit_q % 9 == 0) || (bit_q % 9 == 1))
    else $error("frame not whole bytes");
  chk_tgt_quiet_cond: assert property (cond |-> t_sda_oe_n)
    else $error("target drives at start or stop");
endmodule : cbsr_chk

// *** cbsr_defs.svh ***
`ifndef CBSR_DEFS_SVH
`define CBSR_DEFS_SVH
// What this block does
// - host write: index, count, then data bytes
// - target acks address, index, count, each byte
// - host read: index write, repeated start, read
// - target sends count, then bytes from index
// - host acks count if nonzero, and bytes except last
// - host ends read with nack then stop
// - byte 0 bits 7:6 show latched strap
// - byte 0 bit 3 selects mode source
// - byte 0 bits 2:1 override, reset 11
// - readback keeps strap value after override
// - new mode needs warm reset to apply
// - byte 1 bits 1,2,5,6 enable outputs 0-3
// - byte 2 bits 1,2 enable outputs 4-5
// - index 7 readback count, 0 to 8, default 8

// ****************************************
// target register indices
// ****************************************
`define CBSR_IDX_MODE       8'h00
`define CBSR_IDX_OE_LO      8'h01
`define CBSR_IDX_OE_HI      8'h02
`define CBSR_IDX_RSVD3      8'h03
`define CBSR_IDX_RCOUNT     8'h07

// ****************************************
// target field positions and reset values
// ****************************************
`define CBSR_MODE_RB_HI     7
`define CBSR_MODE_RB_LO     6
`define CBSR_MODE_OVR       3
`define CBSR_MODE_SW_HI     2
`define CBSR_MODE_SW_LO     1
`define CBSR_MODE_SW_RST    2'h3
`define CBSR_OE0_BIT        1
`define CBSR_OE1_BIT        2
`define CBSR_OE2_BIT        5
`define CBSR_OE3_BIT        6
`define CBSR_OE4_BIT        1
`define CBSR_OE5_BIT        2
`define CBSR_OE_LO_RSVD     8'h89
`define CBSR_OE_HI_RSVD     8'h08
`define CBSR_RCOUNT_RST     5'h08
`define CBSR_RCOUNT_MAX     5'h08
`define CBSR_BW_LOW         2'h0
`define CBSR_BW_BYPASS      2'h1
`define CBSR_BW_HIGH        2'h3
// arbitrary target address
`define CBSR_TGT_ADDR       7'h6B

// ****************************************
// host register offsets and fields
// ****************************************
`define CBSR_H_CTRL         6'h00
`define CBSR_H_TARGET       6'h04
`define CBSR_H_INDEX        6'h08
`define CBSR_H_COUNT        6'h0C
`define CBSR_H_STATUS       6'h10
`define CBSR_H_DATA         6'h20
`define CBSR_CTRL_GO        0
`define CBSR_CTRL_READ      1
`define CBSR_STAT_BUSY      0
`define CBSR_STAT_NACK      1
`define CBSR_BUF_DEPTH      8
`define CBSR_BUF_MAX        4'h8

// ****************************************
// timing
// ****************************************
`define CBSR_MCLK_NS        40
`define CBSR_SCL_PERIOD_NS  10000
`define CBSR_QTR_CYC        ((`CBSR_SCL_PERIOD_NS / 4) / `CBSR_MCLK_NS)
`endif

// *** cbsr_host.sv ***
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "cbsr_defs.svh"
module cbsr_host #(
  parameter int QTR = `CBSR_QTR_CYC
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  // serial bus
  cbsr_if.host             bus,
  // avalon-mm slave
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest
);
  cbsr_pkg::cbsr_hstate_t st_q;
  logic [11:0] div_q;
  logic [1:0]  ph_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q;
  logic        samp_q;
  logic [3:0]  k_q;
  logic [3:0]  rxn_q;
  logic        busy_q;
  logic        err_q;
  logic        scl_oe_n_q;
  logic        sda_oe_n_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [6:0]  tgt_q;
  logic [7:0]  idx_q;
  logic [3:0]  cnt_q;
  logic        rd_q;
  logic [7:0]  buf_q [`CBSR_BUF_DEPTH];
  logic        acc_wr;
  logic        go;
  logic        tick;
  logic        is_cond;
  logic        rx_type;
  logic        drv;
  logic        eng_wr;

  function automatic logic [3:0] clamp8(input logic [7:0] v);
    return (v > 8'h08) ? `CBSR_BUF_MAX : v[3:0];
  endfunction : clamp8

  assign bus.h_scl_o        = 1'b0;
  assign bus.h_sda_o        = 1'b0;
  assign bus.h_scl_oe_n     = scl_oe_n_q;
  assign bus.h_sda_oe_n     = sda_oe_n_q;
  assign o_avs_readdata     = rdata_q;
  assign o_avs_waitrequest  = wait_q;
  assign acc_wr  = i_avs_write && !wait_q;
  assign go      = acc_wr && (i_avs_address == `CBSR_H_CTRL) && i_avs_writedata[`CBSR_CTRL_GO] && !busy_q;
  assign tick    = busy_q && (div_q == 12'h000);
  assign is_cond = (st_q == cbsr_pkg::H_START) || (st_q == cbsr_pkg::H_RSTART) || (st_q == cbsr_pkg::H_STOP);
  assign rx_type = (st_q == cbsr_pkg::H_RCOUNT) || (st_q == cbsr_pkg::H_RDATA);
  assign eng_wr  = tick && (ph_q == 2'h3) && (bit_q == 4'h8) && (st_q == cbsr_pkg::H_RDATA);

  always_comb begin
    if (bit_q != 4'h8)                 drv = rx_type ? 1'b1 : sh_q[7];
    else if (st_q == cbsr_pkg::H_RCOUNT) drv = (clamp8(sh_q) == 4'h0);
    else if (st_q == cbsr_pkg::H_RDATA)  drv = ((k_q + 4'h1) == rxn_q);
    else                               drv = 1'b1;
  end

  // ****************************************
  // avalon slave, one wait cycle per access
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
      tgt_q   <= `CBSR_TGT_ADDR;
      idx_q   <= 8'h00;
      cnt_q   <= 4'h0;
      rd_q    <= 1'b0;
    end else begin
      wait_q <= !((i_avs_read || i_avs_write) && wait_q);
      if (i_avs_read && wait_q) begin
        unique case (i_avs_address)
          `CBSR_H_TARGET: rdata_q <= {25'h0, tgt_q};
          `CBSR_H_INDEX:  rdata_q <= {24'h0, idx_q};
          `CBSR_H_COUNT:  rdata_q <= {28'h0, cnt_q};
          `CBSR_H_CTRL:   rdata_q <= {30'h0, rd_q, 1'b0};
          `CBSR_H_STATUS: rdata_q <= {20'h0, rxn_q, 6'h0, err_q, busy_q};
          default:        rdata_q <= i_avs_address[5] ? {24'h0, buf_q[i_avs_address[4:2]]} : 32'h0;
        endcase
      end
      if (acc_wr && !busy_q) begin
        unique case (i_avs_address)
          `CBSR_H_TARGET: tgt_q <= i_avs_writedata[6:0];
          `CBSR_H_INDEX:  idx_q <= i_avs_writedata[7:0];
          `CBSR_H_COUNT:  cnt_q <= clamp8(i_avs_writedata[7:0]);
          `CBSR_H_CTRL:   rd_q  <= i_avs_writedata[`CBSR_CTRL_READ];
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // data buffer
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < `CBSR_BUF_DEPTH; i++) buf_q[i] <= 8'h00;
    end else if (eng_wr) begin
      buf_q[k_q[2:0]] <= sh_q;
    end else if (acc_wr && !busy_q && i_avs_address[5]) begin
      buf_q[i_avs_address[4:2]] <= i_avs_writedata[7:0];
    end
  end

  // ****************************************
  // quarter bit timer
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst)                div_q <= 12'(QTR - 1);
    else if (!busy_q || tick)   div_q <= 12'(QTR - 1);
    else                        div_q <= div_q - 12'h001;
  end

  // ****************************************
  // bit and byte sequencer
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= cbsr_pkg::H_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      samp_q <= 1'b1;
      k_q <= 4'h0;
      rxn_q <= 4'h0;
      busy_q <= 1'b0;
      err_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else if (!busy_q) begin
      if (go) begin
        busy_q <= 1'b1;
        err_q  <= 1'b0;
        st_q   <= cbsr_pkg::H_START;
        ph_q   <= 2'h0;
        bit_q  <= 4'h0;
        k_q    <= 4'h0;
        rxn_q  <= 4'h0;
      end
    end else if (tick) begin
      ph_q <= ph_q + 2'h1;
      unique case (ph_q)
        2'h0: begin
          scl_oe_n_q <= 1'b0;
          sda_oe_n_q <= is_cond ? (st_q != cbsr_pkg::H_STOP) : drv;
        end
        2'h1: scl_oe_n_q <= 1'b1;
        2'h2: begin
          samp_q <= bus.sda;
          if (is_cond) sda_oe_n_q <= (st_q == cbsr_pkg::H_STOP);
        end
        2'h3: begin
          if (st_q != cbsr_pkg::H_STOP) scl_oe_n_q <= 1'b0;
          if (!is_cond && bit_q != 4'h8) begin
            bit_q <= bit_q + 4'h1;
            sh_q  <= {sh_q[6:0], samp_q};
          end else begin
            bit_q <= 4'h0;
            unique case (st_q)
              cbsr_pkg::H_START: begin
                st_q <= cbsr_pkg::H_ADDRW;
                sh_q <= {tgt_q, 1'b0};
              end
              cbsr_pkg::H_ADDRW: begin
                st_q <= samp_q ? cbsr_pkg::H_STOP : cbsr_pkg::H_INDEX;
                err_q <= samp_q;
                sh_q <= idx_q;
              end
              cbsr_pkg::H_INDEX: begin
                err_q <= samp_q;
                sh_q  <= {4'h0, cnt_q};
                if (samp_q)    st_q <= cbsr_pkg::H_STOP;
                else if (rd_q) st_q <= cbsr_pkg::H_RSTART;
                else           st_q <= cbsr_pkg::H_COUNT;
              end
              cbsr_pkg::H_COUNT: begin
                err_q <= samp_q;
                sh_q  <= buf_q[0];
                st_q  <= (samp_q || cnt_q == 4'h0) ? cbsr_pkg::H_STOP : cbsr_pkg::H_WDATA;
              end
              cbsr_pkg::H_WDATA: begin
                err_q <= samp_q;
                k_q   <= k_q + 4'h1;
                sh_q  <= buf_q[3'(k_q + 4'h1)];
                if (samp_q || (k_q + 4'h1) == cnt_q) st_q <= cbsr_pkg::H_STOP;
              end
              cbsr_pkg::H_RSTART: begin
                st_q <= cbsr_pkg::H_ADDRR;
                sh_q <= {tgt_q, 1'b1};
              end
              cbsr_pkg::H_ADDRR: begin
                err_q <= samp_q;
                st_q  <= samp_q ? cbsr_pkg::H_STOP : cbsr_pkg::H_RCOUNT;
              end
              cbsr_pkg::H_RCOUNT: begin
                rxn_q <= clamp8(sh_q);
                st_q  <= (clamp8(sh_q) == 4'h0) ? cbsr_pkg::H_STOP : cbsr_pkg::H_RDATA;
              end
              cbsr_pkg::H_RDATA: begin
                k_q <= k_q + 4'h1;
                if ((k_q + 4'h1) == rxn_q) st_q <= cbsr_pkg::H_STOP;
              end
              cbsr_pkg::H_STOP: begin
                busy_q <= 1'b0;
                st_q   <= cbsr_pkg::H_IDLE;
              end
              default: st_q <= cbsr_pkg::H_STOP;
            endcase
          end
        end
        default: ;
      endcase
    end
  end
endmodule : cbsr_host

// *** cbsr_if.sv ***
`timescale 1ns/1ps
interface cbsr_if;
  logic h_scl_o;
  logic h_scl_oe_n;
  logic h_sda_o;
  logic h_sda_oe_n;
  logic t_sda_o;
  logic t_sda_oe_n;
  logic scl;
  logic sda;

  // open drain with pull-up: low wins
  assign scl = h_scl_oe_n | h_scl_o;
  assign sda = (h_sda_oe_n | h_sda_o) & (t_sda_oe_n | t_sda_o);

  modport host (output h_scl_o, output h_scl_oe_n, output h_sda_o, output h_sda_oe_n,
                input scl, input sda);
  modport target (output t_sda_o, output t_sda_oe_n, input scl, input sda);
endinterface : cbsr_if

// *** cbsr_pkg.sv ***
package cbsr_pkg;
  typedef enum logic [2:0] {
    T_IDLE   = 3'h0,
    T_ADDR   = 3'h1,
    T_INDEX  = 3'h2,
    T_COUNT  = 3'h3,
    T_WDATA  = 3'h4,
    T_RDATA  = 3'h5,
    T_IGNORE = 3'h6
  } cbsr_tstate_t;

  typedef enum logic [3:0] {
    H_IDLE   = 4'h0,
    H_START  = 4'h1,
    H_ADDRW  = 4'h2,
    H_INDEX  = 4'h3,
    H_COUNT  = 4'h4,
    H_WDATA  = 4'h5,
    H_RSTART = 4'h6,
    H_ADDRR  = 4'h7,
    H_RCOUNT = 4'h8,
    H_RDATA  = 4'h9,
    H_STOP   = 4'hA
  } cbsr_hstate_t;
endpackage : cbsr_pkg

// *** cbsr_target.sv ***
`timescale 1ns/1ps
`include "cbsr_defs.svh"
module cbsr_target #(
  parameter logic [6:0] ADDR = `CBSR_TGT_ADDR
) (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  // serial bus
  cbsr_if.target          bus,
  // strap and system
  input  wire logic [1:0] i_bandwidth_strap_pin,
  input  wire logic       i_warm_reset,
  input  wire logic [5:0] i_output_pin_en_n,
  // clock path controls
  output logic [1:0]      o_loop_mode,
  output logic [5:0]      o_output_run
);
  // ****************************************
  // bus conditions
  // ****************************************
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  cbsr_bus_cond u_cond (
    .i_mclk     (i_mclk),
    .i_nrst     (i_nrst),
    .i_scl      (bus.scl),
    .i_sda      (bus.sda),
    .o_scl_rise (scl_rise),
    .o_scl_fall (scl_fall),
    .o_start    (start),
    .o_stop     (stop)
  );

  // ****************************************
  // state
  // ****************************************
  cbsr_pkg::cbsr_tstate_t st_q;
  logic [3:0]             bit_q;
  logic [7:0]             rx_q;
  logic [7:0]             tx_q;
  logic [7:0]             ptr_q;
  logic                   sda_oe_n_q;
  logic                   ack_n_q;
  logic [1:0]             strap_q;
  logic                   latched_q;
  logic                   sw_ovr_q;
  logic [1:0]             sw_mode_q;
  logic [3:0]             en_lo_q;
  logic [1:0]             en_hi_q;
  logic [4:0]             rcount_q;
  logic [1:0]             loop_mode_q;
  logic [5:0]             run_q;
  logic                   wr_en;

  assign bus.t_sda_o    = 1'b0;
  assign bus.t_sda_oe_n = sda_oe_n_q;
  assign o_loop_mode    = loop_mode_q;
  assign o_output_run   = run_q;

  // last data bit of a write byte has been shifted in
  assign wr_en = scl_fall && (bit_q == 4'h7) && (st_q == cbsr_pkg::T_WDATA);

  // ****************************************
  // register read decode
  // ****************************************
  function automatic logic [7:0] rd_byte(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      `CBSR_IDX_MODE: begin
        v[`CBSR_MODE_RB_HI]                   = strap_q[1];
        v[`CBSR_MODE_RB_LO]                   = strap_q[0];
        v[`CBSR_MODE_OVR]                     = sw_ovr_q;
        v[`CBSR_MODE_SW_HI:`CBSR_MODE_SW_LO]  = sw_mode_q;
      end
      `CBSR_IDX_OE_LO: begin
        v                = `CBSR_OE_LO_RSVD;
        v[`CBSR_OE0_BIT] = en_lo_q[0];
        v[`CBSR_OE1_BIT] = en_lo_q[1];
        v[`CBSR_OE2_BIT] = en_lo_q[2];
        v[`CBSR_OE3_BIT] = en_lo_q[3];
      end
      `CBSR_IDX_OE_HI: begin
        v                = `CBSR_OE_HI_RSVD;
        v[`CBSR_OE4_BIT] = en_hi_q[0];
        v[`CBSR_OE5_BIT] = en_hi_q[1];
      end
      `CBSR_IDX_RCOUNT: v = {3'h0, rcount_q};
      default:          v = 8'h00;
    endcase
    return v;
  endfunction : rd_byte

  // ****************************************
  // serial protocol
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q       <= cbsr_pkg::T_IDLE;
      bit_q      <= 4'h0;
      rx_q       <= 8'h00;
      tx_q       <= 8'h00;
      ptr_q      <= 8'h00;
      sda_oe_n_q <= 1'b1;
      ack_n_q    <= 1'b1;
    end else if (stop) begin
      st_q       <= cbsr_pkg::T_IDLE;
      bit_q      <= 4'h0;
      sda_oe_n_q <= 1'b1;
    end else if (start) begin
      // repeated start lands here too, keeping the index
      // the start's own scl fall then closes like an ack slot
      st_q       <= cbsr_pkg::T_ADDR;
      bit_q      <= 4'h8;
      sda_oe_n_q <= 1'b1;
    end else if (scl_rise) begin
      if (bit_q != 4'h8) begin
        rx_q <= {rx_q[6:0], bus.sda};
      end else begin
        ack_n_q <= bus.sda;
      end
    end else if (scl_fall && st_q != cbsr_pkg::T_IDLE && st_q != cbsr_pkg::T_IGNORE) begin
      if (bit_q == 4'h7) begin
        bit_q <= 4'h8;
        if (st_q == cbsr_pkg::T_RDATA) begin
          // next byte from the running index
          sda_oe_n_q <= 1'b1;
          tx_q       <= rd_byte(ptr_q);
          ptr_q      <= ptr_q + 8'h01;
        end else begin
          sda_oe_n_q <= 1'b0;
          unique case (st_q)
            cbsr_pkg::T_ADDR: begin
              if (rx_q[7:1] != ADDR) begin
                st_q       <= cbsr_pkg::T_IGNORE;
                sda_oe_n_q <= 1'b1;
              end else if (rx_q[0]) begin
                st_q <= cbsr_pkg::T_RDATA;
                tx_q <= {3'h0, rcount_q};
              end else begin
                st_q <= cbsr_pkg::T_INDEX;
              end
            end
            cbsr_pkg::T_INDEX: begin
              ptr_q <= rx_q;
              st_q  <= cbsr_pkg::T_COUNT;
            end
            cbsr_pkg::T_COUNT: st_q  <= cbsr_pkg::T_WDATA;
            cbsr_pkg::T_WDATA: ptr_q <= ptr_q + 8'h01;
            default:           st_q  <= cbsr_pkg::T_IGNORE;
          endcase
        end
      end else if (bit_q == 4'h8) begin
        bit_q <= 4'h0;
        if (st_q == cbsr_pkg::T_RDATA) begin
          if (ack_n_q) begin
            st_q       <= cbsr_pkg::T_IGNORE;
            sda_oe_n_q <= 1'b1;
          end else begin
            sda_oe_n_q <= tx_q[7];
          end
        end else begin
          sda_oe_n_q <= 1'b1;
        end
      end else begin
        bit_q <= bit_q + 4'h1;
        if (st_q == cbsr_pkg::T_RDATA) begin
          tx_q       <= {tx_q[6:0], 1'b0};
          sda_oe_n_q <= tx_q[6];
        end
      end
    end
  end

  // ****************************************
  // strap latch and loop mode
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      strap_q     <= `CBSR_BW_HIGH;
      latched_q   <= 1'b0;
      loop_mode_q <= `CBSR_BW_HIGH;
    end else if (!latched_q) begin
      // strap caught once after reset release
      strap_q     <= i_bandwidth_strap_pin;
      latched_q   <= 1'b1;
      loop_mode_q <= i_bandwidth_strap_pin;
    end else if (i_warm_reset) begin
      // mode change applies on warm reset
      loop_mode_q <= sw_ovr_q ? sw_mode_q : strap_q;
    end
  end

  // ****************************************
  // writable registers
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sw_ovr_q  <= 1'b0;
      sw_mode_q <= `CBSR_MODE_SW_RST;
      en_lo_q   <= 4'hF;
      en_hi_q   <= 2'h3;
      rcount_q  <= `CBSR_RCOUNT_RST;
    end else if (wr_en) begin
      unique case (ptr_q)
        `CBSR_IDX_MODE: begin
          sw_ovr_q  <= rx_q[`CBSR_MODE_OVR];
          sw_mode_q <= rx_q[`CBSR_MODE_SW_HI:`CBSR_MODE_SW_LO];
        end
        // enables for outputs 0 to 3
        `CBSR_IDX_OE_LO: en_lo_q <= {rx_q[`CBSR_OE3_BIT], rx_q[`CBSR_OE2_BIT],
                                     rx_q[`CBSR_OE1_BIT], rx_q[`CBSR_OE0_BIT]};
        // enables for outputs 4 and 5
        `CBSR_IDX_OE_HI: en_hi_q <= {rx_q[`CBSR_OE5_BIT], rx_q[`CBSR_OE4_BIT]};
        `CBSR_IDX_RCOUNT: begin
          if (rx_q[4:0] <= `CBSR_RCOUNT_MAX && rx_q[7:5] == 3'h0) begin
            rcount_q <= rx_q[4:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // output gating
  // ****************************************
  // a cleared enable bit beats the pin
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      run_q <= 6'h00;
    end else begin
      run_q <= {en_hi_q, en_lo_q} & ~i_output_pin_en_n;
    end
  end
endmodule : cbsr_target

// *** tb_clock_buffer_smbus_regs.sv ***
`timescale 1ns/1ps
`include "cbsr_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_clock_buffer_smbus_regs;
  localparam int QTR = 4;
  logic        mclk = 1'b0;
  logic        nrst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        warm_reset = 1'b0;
  logic [5:0]  pin_en_n = 6'h00;
  logic [1:0]  loop_mode;
  logic [5:0]  output_run;
  logic [31:0] q;
  logic [31:0] st;
  logic [1:0]  m;
  logic [1:0]  strap = 2'h1;
  int          num_errors = 0;
  int          comparisons = 0;
  logic [7:0]  rst_img [8] = '{8'h46, 8'hEF, 8'h0E, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
  logic [1:0]  codes [3] = '{`CBSR_BW_LOW, `CBSR_BW_BYPASS, `CBSR_BW_HIGH};
  // index, write byte, readback, outputs running
  logic [29:0] rows [8] = '{{8'h01, 8'h00, 8'h89, 6'h30}, {8'h01, 8'hFF, 8'hEF, 6'h3F},
    {8'h02, 8'h00, 8'h08, 6'h0F}, {8'h02, 8'hFF, 8'h0E, 6'h3F}, {8'h00, 8'h0F, 8'h4E, 6'h3F},
    {8'h00, 8'hB1, 8'h40, 6'h3F}, {8'h03, 8'hFF, 8'h00, 6'h3F}, {8'h07, 8'h09, 8'h08, 6'h3F}};
  always #20 mclk = ~mclk;
  cbsr_if i_cbsr_if ();
  cbsr_host #(.QTR(QTR)) i_cbsr_host (.i_mclk(mclk), .i_nrst(nrst), .bus(i_cbsr_if),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest));
  // strap starts at bypass so readback differs from the override reset code
  cbsr_target i_cbsr_target (.i_mclk(mclk), .i_nrst(nrst), .bus(i_cbsr_if), .i_bandwidth_strap_pin(strap),
    .i_warm_reset(warm_reset), .i_output_pin_en_n(pin_en_n), .o_loop_mode(loop_mode), .o_output_run(output_run));
  cbsr_chk #(.QTR(QTR)) i_cbsr_chk (.i_mclk(mclk), .i_nrst(nrst), .h_scl_oe_n(i_cbsr_if.h_scl_oe_n),
    .h_sda_oe_n(i_cbsr_if.h_sda_oe_n), .t_sda_oe_n(i_cbsr_if.t_sda_oe_n), .scl(i_cbsr_if.scl), .sda(i_cbsr_if.sda));
  task give_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task av(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    logic w;
    n = 0;
    w = 1'b1;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    // settled values, as the next rising edge will see them
    while (w && n < 50) begin
      @(negedge mclk);
      w = (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      @(posedge mclk);
      n++;
    end
    if (w) begin
      num_errors++;
      give_verdict();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : av
  task xfer(input logic rd, input logic [7:0] idx, input logic [3:0] n);
    int k;
    av(1'b1, `CBSR_H_INDEX, {24'h0, idx});
    av(1'b1, `CBSR_H_COUNT, {28'h0, n});
    av(1'b1, `CBSR_H_CTRL, {30'h0, rd, 1'b1});
    st = 32'h1;
    k = 0;
    while (st[`CBSR_STAT_BUSY] !== 1'b0 && k < 3000) begin
      av(1'b0, `CBSR_H_STATUS, 32'h0);
      st = q;
      k++;
    end
    if (k == 3000) begin
      num_errors++;
      give_verdict();
    end
  endtask : xfer
  task warm;
    warm_reset <= 1'b1;
    @(posedge mclk);
    warm_reset <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : warm
  initial begin
    // falling edge at time zero resets every flop before the first clock
    nrst <= 1'b0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK(loop_mode, 2'h1)
    `CHK(output_run, 6'h3F)
    xfer(1'b1, 8'h00, 4'h0);
    `CHK(st[11:8], 4'h8)
    for (int i = 0; i < 8; i++) begin
      av(1'b0, 6'(32 + 4 * i), 32'h0);
      `CHK(q[7:0], rst_img[i])
    end
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      av(1'b1, `CBSR_H_DATA, {24'h0, rows[i][21:14]});
      xfer(1'b0, rows[i][29:22], 4'h1);
      xfer(1'b1, rows[i][29:22], 4'h0);
      av(1'b0, `CBSR_H_DATA, 32'h0);
      `CHK(q[7:0], rows[i][13:6])
      `CHK(output_run, rows[i][5:0])
    end
    $display("row table done");
    m = 2'h1;
    for (int c = 0; c < 3; c++) begin
      av(1'b1, `CBSR_H_DATA, {24'h0, 4'h0, 1'b1, codes[c], 1'b0});
      xfer(1'b0, 8'h00, 4'h1);
      `CHK(loop_mode, m)
      warm();
      m = codes[c];
      `CHK(loop_mode, m)
      xfer(1'b1, 8'h00, 4'h0);
      av(1'b0, `CBSR_H_DATA, 32'h0);
      `CHK(q[7:0], {2'h1, 3'h1, codes[c], 1'b0})
    end
    av(1'b1, `CBSR_H_DATA, 32'h06);
    xfer(1'b0, 8'h00, 4'h1);
    warm();
    `CHK(loop_mode, 2'h1)
    $display("mode override done");
    av(1'b1, `CBSR_H_DATA, 32'h00);
    av(1'b1, 6'h24, 32'h02);
    xfer(1'b0, 8'h01, 4'h2);
    xfer(1'b1, 8'h01, 4'h0);
    av(1'b0, `CBSR_H_DATA, 32'h0);
    `CHK(q[7:0], 8'h89)
    av(1'b0, 6'h24, 32'h0);
    `CHK(q[7:0], 8'h0A)
    `CHK(output_run, 6'h10)
    pin_en_n <= 6'h10;
    repeat (3) @(posedge mclk);
    `CHK(output_run, 6'h00)
    pin_en_n <= 6'h00;
    $display("block write done");
    av(1'b1, `CBSR_H_DATA, 32'h01);
    xfer(1'b0, 8'h07, 4'h1);
    xfer(1'b1, 8'h00, 4'h0);
    `CHK(st[11:8], 4'h1)
    av(1'b0, `CBSR_H_DATA, 32'h0);
    `CHK(q[7:0], 8'h46)
    av(1'b1, `CBSR_H_TARGET, 32'h10);
    xfer(1'b0, 8'h01, 4'h1);
    `CHK(st[`CBSR_STAT_NACK], 1'b1)
    av(1'b0, 6'h3C, 32'h0);
    `CHK(q, 32'h0)
    $display("awkward cases done");
    strap <= `CBSR_BW_LOW;
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK({avs_waitrequest, output_run, loop_mode}, 9'h103)
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK(loop_mode, `CBSR_BW_LOW)
    xfer(1'b1, 8'h00, 4'h0);
    `CHK(st[11:8], 4'h8)
    av(1'b0, `CBSR_H_DATA, 32'h0);
    `CHK(q[7:0], 8'h06)
    $display("second reset done");
    give_verdict();
  end
endmodule : tb_clock_buffer_smbus_regs
